// ---- verilog/tpe_pkg.sv ----
package tpe_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 32;
    // register offsets (byte addresses)
    localparam logic [15:0] OFS_ERR_CTRL    = 16'h8E88;
    localparam logic [15:0] OFS_ERR_STATUS  = 16'h8E90;
    localparam logic [15:0] OFS_INJECT_CTRL = 16'h8EC0;
    localparam logic [15:0] OFS_IRQ_STATUS  = 16'h8F00;
    localparam logic [15:0] OFS_IRQ_MASK    = 16'h8F04;
    localparam logic [15:0] OFS_SEC_CTRL    = 16'h8F08;
    // reset values
    localparam logic [31:0] RST_ERR_CTRL    = 32'h0000_0008;
    localparam logic [31:0] RST_INJECT_CTRL = 32'h0000_0000;
    // field positions
    localparam int          BIT_INJ_DATA    = 0;
    localparam int          BIT_INJ_TAG     = 1;
    localparam int          BIT_FI_EN       = 3;
    localparam int          BIT_NS_RAS      = 0;
    localparam int          BIT_ST_V        = 30;
    localparam int          BIT_ST_OF       = 27;
    localparam int          POS_ST_CE       = 24;
    localparam int          POS_ST_ERROR_SYNDROME_CODE     = 0;
    localparam int          BIT_PROT_NS     = 1;
    // status codes
    localparam logic [1:0]  CE_NONE         = 2'h0;
    localparam logic [1:0]  CE_CORRECTED    = 2'h2;
    localparam logic [1:0]  CE_CLEAR_CODE   = 2'h3;
    localparam logic [7:0]  ERROR_SYNDROME_CODE_NONE       = 8'h00;
    localparam logic [7:0]  ERROR_SYNDROME_CODE_TAG        = 8'h07;
    localparam logic [7:0]  ERROR_SYNDROME_CODE_DATA       = 8'h08;
    // interrupt status bits
    localparam int          IRQ_N           = 3;
    localparam int          IRQ_TAG_FAULT   = 0;
    localparam int          IRQ_DATA_FAULT  = 1;
    localparam int          IRQ_OVERFLOW    = 2;
endpackage

// ---- verilog/tpe_fault_rec.sv ----
module tpe_fault_rec
    import tpe_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        fault_i,
    input  wire logic        tag_err_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] wdata_i,
    output logic             valid_o,
    output logic             ovf_o,
    output logic [1:0]       ce_o,
    output logic [7:0]       error_syndrome_code_o
);
    logic       v_q, v_d;
    logic       of_q, of_d;
    logic [1:0] ce_q, ce_d;
    logic [7:0] error_syndrome_code_q, error_syndrome_code_d;
    logic       clr_of, clr_ce, clr_v;

    always_comb
    begin
        clr_of = wr_i && wdata_i[BIT_ST_OF];
        clr_ce = wr_i && (wdata_i[POS_ST_CE +: 2] == CE_CLEAR_CODE)
                 && (!of_q || clr_of);
        clr_v  = wr_i && wdata_i[BIT_ST_V] && (ce_q == CE_NONE || clr_ce);
        v_d    = clr_v ? 1'b0 : v_q;
        of_d   = clr_of ? 1'b0 : of_q;
        ce_d   = clr_ce ? CE_NONE : ce_q;
        error_syndrome_code_d = clr_ce ? ERROR_SYNDROME_CODE_NONE : error_syndrome_code_q;
        // a fault in the clearing cycle wins over the clear
        if (fault_i)
        begin
            v_d = 1'b1;
            ce_d = CE_CORRECTED;
            if (ce_q != CE_NONE && !clr_ce)
                of_d = 1'b1;
            else
                error_syndrome_code_d = tag_err_i ? ERROR_SYNDROME_CODE_TAG : ERROR_SYNDROME_CODE_DATA;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            v_q    <= 1'b0;
            of_q   <= 1'b0;
            ce_q   <= CE_NONE;
            error_syndrome_code_q <= ERROR_SYNDROME_CODE_NONE;
        end
        else
        begin
            v_q    <= v_d;
            of_q   <= of_d;
            ce_q   <= ce_d;
            error_syndrome_code_q <= error_syndrome_code_d;
        end
    end

    assign valid_o = v_q;
    assign ovf_o   = of_q;
    assign ce_o    = ce_q;
    assign error_syndrome_code_o  = error_syndrome_code_q;

    a_tag_code: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        fault_i && tag_err_i && ce_q == CE_NONE |=> error_syndrome_code_q == ERROR_SYNDROME_CODE_TAG)
        else $error("tag fault not coded 0x07");
    a_data_code: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        fault_i && !tag_err_i && ce_q == CE_NONE |=> error_syndrome_code_q == ERROR_SYNDROME_CODE_DATA)
        else $error("data fault not coded 0x08");
    a_ce_set: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        fault_i |=> ce_q == CE_CORRECTED && v_q)
        else $error("fault did not set corrected status");
    a_ovf_set: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        fault_i && ce_q != CE_NONE && !wr_i |=> of_q && $stable(error_syndrome_code_q))
        else $error("second fault did not set overflow");
endmodule

// ---- verilog/tpe_irq_ctl.sv ----
module tpe_irq_ctl
    import tpe_pkg::*;
#(
    parameter int N = IRQ_N
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [N-1:0] event_i,
    input  wire logic         status_wr_i,
    input  wire logic         mask_wr_i,
    input  wire logic [N-1:0] wdata_i,
    output logic [N-1:0]      status_o,
    output logic [N-1:0]      mask_o,
    output logic              irq_o
);
    logic [N-1:0] status_q, status_d;
    logic [N-1:0] mask_q, mask_d;

    always_comb
    begin
        // sticky, write one to clear; a new event wins
        status_d = (status_q & ~(status_wr_i ? wdata_i : '0)) | event_i;
        mask_d   = mask_wr_i ? wdata_i : mask_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            status_q <= '0;
            mask_q   <= '0;
        end
        else
        begin
            status_q <= status_d;
            mask_q   <= mask_d;
        end
    end

    assign status_o = status_q;
    assign mask_o   = mask_q;
    assign irq_o    = |(status_q & mask_q);

    a_event_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        |event_i |=> (status_q & $past(event_i)) == $past(event_i))
        else $error("event lost from status");
endmodule

// ---- verilog/tpe_inject_top.sv ----
// Our own choice: the APB interface to the registers.
module tpe_inject_top
    import tpe_pkg::*;
(
    input  wire logic                 CORE_CLK_I,
    input  wire logic                 RST_N_I,
    input  wire logic                 PSEL_I,
    input  wire logic                 PENABLE_I,
    input  wire logic                 PWRITE_I,
    input  wire logic [tpe_pkg::ADDR_W-1:0] PADDR_I,
    input  wire logic [tpe_pkg::DATA_W-1:0] PWDATA_I,
    input  wire logic [2:0]           PPROT_I,
    output logic                      PREADY_O,
    output logic [tpe_pkg::DATA_W-1:0] PRDATA_O,
    output logic                      PSLVERR_O,
    input  wire logic                 TLB_WRITE_I,
    output logic                      TLB_WR_TAG_PERR_O,
    output logic                      TLB_WR_DATA_PERR_O,
    input  wire logic                 TLB_USE_I,
    input  wire logic                 TLB_TAG_PERR_I,
    input  wire logic                 TLB_DATA_PERR_I,
    input  wire logic                 TLB_INJECTED_I,
    output logic                      FAULT_O,
    output logic                      FMU_REPORT_O,
    output logic                      RAS_IRPT_O,
    output logic                      IRQ_O
);
    logic [1:0]       inject_q, inject_d;
    logic             fi_en_q, fi_en_d;
    logic             ns_ras_q, ns_ras_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             slverr_q, slverr_d;
    logic             wr_tag_q, wr_tag_d;
    logic             wr_data_q, wr_data_d;
    logic             fault_q, fault_d;
    logic             fmu_q, fmu_d;
    logic             setup, access, wr_acc, nonsecure, allowed, hit;
    logic             fault_now, tag_now;
    logic             st_v, st_of;
    logic [1:0]       st_ce;
    logic [7:0]       st_error_syndrome_code;
    logic [IRQ_N-1:0] irq_status, irq_mask, irq_event;

    function automatic logic addr_is(input logic [15:0] a,
                                     input logic [15:0] ofs);
        return a == ofs;
    endfunction

    assign setup     = PSEL_I && !PENABLE_I;
    assign access    = PSEL_I && PENABLE_I;
    assign wr_acc    = access && PWRITE_I && !slverr_q;
    assign nonsecure = PPROT_I[BIT_PROT_NS];
    assign allowed   = !nonsecure || ns_ras_q;
    assign hit = addr_is(PADDR_I, OFS_ERR_CTRL)
              || addr_is(PADDR_I, OFS_ERR_STATUS)
              || addr_is(PADDR_I, OFS_INJECT_CTRL)
              || addr_is(PADDR_I, OFS_IRQ_STATUS)
              || addr_is(PADDR_I, OFS_IRQ_MASK)
              || addr_is(PADDR_I, OFS_SEC_CTRL);

    assign fault_now = TLB_USE_I && (TLB_TAG_PERR_I || TLB_DATA_PERR_I);
    assign tag_now   = TLB_TAG_PERR_I;

    always_comb
    begin
        inject_d  = inject_q;
        fi_en_d   = fi_en_q;
        ns_ras_d  = ns_ras_q;
        rdata_d   = rdata_q;
        slverr_d  = slverr_q;
        if (setup)
        begin
            slverr_d = !hit;
            rdata_d  = '0;
            if (allowed && !PWRITE_I)
            begin
                if (addr_is(PADDR_I, OFS_INJECT_CTRL))
                    rdata_d[1:0] = inject_q;
                if (addr_is(PADDR_I, OFS_ERR_CTRL))
                    rdata_d[BIT_FI_EN] = fi_en_q;
                if (addr_is(PADDR_I, OFS_ERR_STATUS))
                begin
                    rdata_d[BIT_ST_V]          = st_v;
                    rdata_d[BIT_ST_OF]         = st_of;
                    rdata_d[POS_ST_CE +: 2]    = st_ce;
                    rdata_d[POS_ST_ERROR_SYNDROME_CODE +: 8]  = st_error_syndrome_code;
                end
                if (addr_is(PADDR_I, OFS_IRQ_STATUS))
                    rdata_d[IRQ_N-1:0] = irq_status;
                if (addr_is(PADDR_I, OFS_IRQ_MASK))
                    rdata_d[IRQ_N-1:0] = irq_mask;
            end
            if (!nonsecure && !PWRITE_I && addr_is(PADDR_I, OFS_SEC_CTRL))
                rdata_d[BIT_NS_RAS] = ns_ras_q;
        end
        if (wr_acc && allowed)
        begin
            if (addr_is(PADDR_I, OFS_INJECT_CTRL))
                inject_d = PWDATA_I[BIT_INJ_TAG:BIT_INJ_DATA];
            if (addr_is(PADDR_I, OFS_ERR_CTRL))
                fi_en_d = PWDATA_I[BIT_FI_EN];
        end
        if (wr_acc && !nonsecure && addr_is(PADDR_I, OFS_SEC_CTRL))
            ns_ras_d = PWDATA_I[BIT_NS_RAS];
    end

    always_comb
    begin
        wr_tag_d  = TLB_WRITE_I && inject_q[BIT_INJ_TAG];
        wr_data_d = TLB_WRITE_I && inject_q[BIT_INJ_DATA];
        fault_d   = fault_now;
        fmu_d     = fault_now && !TLB_INJECTED_I;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            inject_q  <= RST_INJECT_CTRL[1:0];
            fi_en_q   <= RST_ERR_CTRL[BIT_FI_EN];
            ns_ras_q  <= 1'b0;
            rdata_q   <= '0;
            slverr_q  <= 1'b0;
            wr_tag_q  <= 1'b0;
            wr_data_q <= 1'b0;
            fault_q   <= 1'b0;
            fmu_q     <= 1'b0;
        end
        else
        begin
            inject_q  <= inject_d;
            fi_en_q   <= fi_en_d;
            ns_ras_q  <= ns_ras_d;
            rdata_q   <= rdata_d;
            slverr_q  <= slverr_d;
            wr_tag_q  <= wr_tag_d;
            wr_data_q <= wr_data_d;
            fault_q   <= fault_d;
            fmu_q     <= fmu_d;
        end
    end

    tpe_fault_rec u_rec (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .fault_i   (fault_now),
        .tag_err_i (tag_now),
        .wr_i      (wr_acc && allowed
                    && addr_is(PADDR_I, OFS_ERR_STATUS)),
        .wdata_i   (PWDATA_I),
        .valid_o   (st_v),
        .ovf_o     (st_of),
        .ce_o      (st_ce),
        .error_syndrome_code_o    (st_error_syndrome_code)
    );

    always_comb
    begin
        irq_event = '0;
        irq_event[IRQ_TAG_FAULT]  = fault_now && tag_now;
        irq_event[IRQ_DATA_FAULT] = fault_now && !tag_now;
        irq_event[IRQ_OVERFLOW]   = fault_now && st_ce != CE_NONE;
    end

    tpe_irq_ctl #(.N(IRQ_N)) u_irq (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .event_i     (irq_event),
        .status_wr_i (wr_acc && allowed
                      && addr_is(PADDR_I, OFS_IRQ_STATUS)),
        .mask_wr_i   (wr_acc && allowed
                      && addr_is(PADDR_I, OFS_IRQ_MASK)),
        .wdata_i     (PWDATA_I[IRQ_N-1:0]),
        .status_o    (irq_status),
        .mask_o      (irq_mask),
        .irq_o       (IRQ_O)
    );

    assign PREADY_O           = 1'b1;
    assign PRDATA_O           = rdata_q;
    assign PSLVERR_O          = access && slverr_q;
    assign TLB_WR_TAG_PERR_O  = wr_tag_q;
    assign TLB_WR_DATA_PERR_O = wr_data_q;
    assign FAULT_O            = fault_q;
    assign FMU_REPORT_O       = fmu_q;
    assign RAS_IRPT_O         = fi_en_q && st_v;

    a_ns_raz: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        setup && nonsecure && !ns_ras_q |=> PRDATA_O == '0)
        else $error("non-secure read not zero");
    a_ns_wi: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        access && nonsecure && !ns_ras_q |=> $stable(inject_q)
        && $stable(fi_en_q))
        else $error("non-secure write took effect");
    a_sec_ctrl_wi: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        access && PWRITE_I && nonsecure |=> $stable(ns_ras_q))
        else $error("non-secure write changed access control");

    a_tag_inject: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        TLB_WRITE_I |=> TLB_WR_TAG_PERR_O == $past(inject_q[BIT_INJ_TAG]))
        else $error("tag inject mismatch");
    a_data_inject: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        TLB_WRITE_I |=> TLB_WR_DATA_PERR_O == $past(inject_q[BIT_INJ_DATA]))
        else $error("data inject mismatch");
    a_wr_quiet: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        !TLB_WRITE_I |=> !TLB_WR_TAG_PERR_O && !TLB_WR_DATA_PERR_O)
        else $error("parity error marked without a buffer write");

    a_no_fmu: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && TLB_INJECTED_I |=> FAULT_O && !FMU_REPORT_O)
        else $error("injected fault sent to fault manager");
    a_fmu_real: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && !TLB_INJECTED_I |=> FAULT_O && FMU_REPORT_O)
        else $error("real fault not sent to fault manager");
    a_fault_quiet: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        !fault_now |=> !FAULT_O && !FMU_REPORT_O)
        else $error("fault reported without a parity error");
    a_inj_corrected: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && TLB_INJECTED_I |=> st_v && st_ce == CE_CORRECTED)
        else $error("injected fault not recorded as correctable");

    a_tag_irq: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && TLB_TAG_PERR_I |=> irq_status[IRQ_TAG_FAULT])
        else $error("tag fault not flagged");
    a_tag_hides: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && TLB_TAG_PERR_I && !irq_status[IRQ_DATA_FAULT]
        |=> !irq_status[IRQ_DATA_FAULT])
        else $error("data fault flagged beside a tag fault");

    a_irq_gate: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && fi_en_q && !PSEL_I |=> RAS_IRPT_O)
        else $error("fault interrupt missing");
    a_irq_off: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        !fi_en_q |-> !RAS_IRPT_O)
        else $error("interrupt while disabled");
    a_irq_out: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        fault_now && TLB_TAG_PERR_I && irq_mask[IRQ_TAG_FAULT] && !PSEL_I
        |=> IRQ_O)
        else $error("unmasked tag fault gave no interrupt");
    a_irq_quiet: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        irq_mask == '0 && !PSEL_I |=> !IRQ_O)
        else $error("interrupt with all sources masked");

    a_reset_clear: assert property (@(posedge CORE_CLK_I)
        !RST_N_I |=> inject_q == 2'h0 && !TLB_WR_TAG_PERR_O)
        else $error("inject bits not clear after reset");
    a_inject_write: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        access && PWRITE_I && allowed && addr_is(PADDR_I, OFS_INJECT_CTRL)
        |=> inject_q == $past(PWDATA_I[BIT_INJ_TAG:BIT_INJ_DATA]))
        else $error("inject write not stored");
    a_inject_hold: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        !(access && PWRITE_I) |=> $stable(inject_q))
        else $error("inject bits changed without a write");
    a_rdata_inject: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        setup && allowed && !PWRITE_I && addr_is(PADDR_I, OFS_INJECT_CTRL)
        |=> PRDATA_O == {30'h0, $past(inject_q)})
        else $error("inject read wrong or reserved bits set");

    a_unmapped_err: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        setup && !hit ##1 access |-> PSLVERR_O)
        else $error("unmapped access gave no error");
    a_unmapped_rd: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        setup && !hit |=> PRDATA_O == '0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (@(posedge CORE_CLK_I)
        disable iff (!RST_N_I)
        !setup |=> $stable(PRDATA_O))
        else $error("read data moved outside a setup cycle");
    c_tag_write: cover property (@(posedge CORE_CLK_I) TLB_WR_TAG_PERR_O);
    c_both_fault: cover property (@(posedge CORE_CLK_I)
        fault_now && TLB_TAG_PERR_I && TLB_DATA_PERR_I);
    c_overflow: cover property (@(posedge CORE_CLK_I) st_of);
    c_ns_block: cover property (@(posedge CORE_CLK_I)
        access && nonsecure && !ns_ras_q);
    c_ns_open: cover property (@(posedge CORE_CLK_I)
        access && nonsecure && ns_ras_q);
endmodule

// ---- testbench/tb_top.sv ----
module tb_top;
    import tpe_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [2:0]  pprot;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        tlb_write;
    logic        tag_perr_w;
    logic        data_perr_w;
    logic        tlb_use;
    logic        tag_perr;
    logic        data_perr;
    logic        injected;
    logic        fault;
    logic        fmu_report;
    logic        ras_irpt;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          failures;
    int          comparisons;

    tpe_inject_top dut_u (
        .CORE_CLK_I         (core_clk),
        .RST_N_I            (rst_n),
        .PSEL_I             (psel),
        .PENABLE_I          (penable),
        .PWRITE_I           (pwrite),
        .PADDR_I            (paddr),
        .PWDATA_I           (pwdata),
        .PPROT_I            (pprot),
        .PREADY_O           (pready),
        .PRDATA_O           (prdata),
        .PSLVERR_O          (pslverr),
        .TLB_WRITE_I        (tlb_write),
        .TLB_WR_TAG_PERR_O  (tag_perr_w),
        .TLB_WR_DATA_PERR_O (data_perr_w),
        .TLB_USE_I          (tlb_use),
        .TLB_TAG_PERR_I     (tag_perr),
        .TLB_DATA_PERR_I    (data_perr),
        .TLB_INJECTED_I     (injected),
        .FAULT_O            (fault),
        .FMU_REPORT_O       (fmu_report),
        .RAS_IRPT_O         (ras_irpt),
        .IRQ_O              (irq)
    );

    always #50 core_clk = ~core_clk;

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; waits for pready at a bounded count
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d, input logic ns);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pprot   <= {1'b0, ns, 1'b0};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            check("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic ns);
        apb(1'b1, a, d, ns);
    endtask

    task automatic rd_chk(input string name, input logic [15:0] a,
                          input logic [31:0] exp, input logic ns);
        apb(1'b0, a, 32'h0000_0000, ns);
        check(name, exp, rd);
    endtask

    task automatic tlb_wr(input logic exp_tag, input logic exp_data);
        @(posedge core_clk);
        tlb_write <= 1'b1;
        @(posedge core_clk);
        tlb_write <= 1'b0;
        #1;
        check("wr_tag_perr", {31'h0, exp_tag}, {31'h0, tag_perr_w});
        check("wr_data_perr", {31'h0, exp_data}, {31'h0, data_perr_w});
        @(posedge core_clk);
        #1;
        check("wr_perr_after", 32'h0, {30'h0, tag_perr_w, data_perr_w});
    endtask

    // expected: {fault, fmu_report, ras_irpt, irq}
    task automatic use_entry(input logic t, input logic d, input logic inj,
                             input logic [3:0] exp);
        @(posedge core_clk);
        tlb_use   <= 1'b1;
        tag_perr  <= t;
        data_perr <= d;
        injected  <= inj;
        @(posedge core_clk);
        tlb_use   <= 1'b0;
        tag_perr  <= 1'b0;
        data_perr <= 1'b0;
        injected  <= 1'b0;
        #1;
        check("use_outputs", {28'h0, exp},
              {28'h0, fault, fmu_report, ras_irpt, irq});
        @(posedge core_clk);
        #1;
        check("fault_pulse_end", 32'h0, {30'h0, fault, fmu_report});
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
        {tlb_write, tlb_use, tag_perr, data_perr, injected} = '0;
        failures = 0;
        comparisons = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk("inject_rst", OFS_INJECT_CTRL, RST_INJECT_CTRL, 1'b0);
        rd_chk("errctl_rst", OFS_ERR_CTRL, RST_ERR_CTRL, 1'b0);
        wr(OFS_ERR_CTRL, 32'hFFFF_FFFF, 1'b0);
        rd_chk("errctl_rsvd", OFS_ERR_CTRL, 32'h0000_0008, 1'b0);
        rd_chk("status_rst", OFS_ERR_STATUS, 32'h0, 1'b0);
        tlb_wr(1'b0, 1'b0);
        wr(OFS_INJECT_CTRL, 32'hFFFF_FFFF, 1'b0);
        rd_chk("inject_rsvd", OFS_INJECT_CTRL, 32'h0000_0003, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_INJECT_CTRL, k, 1'b0);
            tlb_wr(k[1], k[0]);
        end
        wr(OFS_INJECT_CTRL, 32'h0000_0001, 1'b0);
        wr(OFS_INJECT_CTRL, 32'h0000_0002, 1'b1);
        rd_chk("ns_write_drop", OFS_INJECT_CTRL, 32'h1, 1'b0);
        rd_chk("ns_read_zero", OFS_INJECT_CTRL, 32'h0, 1'b1);
        check("ns_no_err", 32'h0, {31'h0, err});
        wr(OFS_SEC_CTRL, 32'h0000_0001, 1'b0);
        rd_chk("ns_read_open", OFS_INJECT_CTRL, 32'h1, 1'b1);
        wr(OFS_INJECT_CTRL, 32'h0000_0002, 1'b1);
        rd_chk("ns_write_open", OFS_INJECT_CTRL, 32'h2, 1'b0);
        wr(OFS_SEC_CTRL, 32'h0000_0000, 1'b1);
        rd_chk("sec_ctrl_ns_wi", OFS_SEC_CTRL, 32'h1, 1'b0);
        wr(OFS_SEC_CTRL, 32'h0000_0000, 1'b0);
        rd_chk("unmapped_read", 16'h8F0C, 32'h0, 1'b0);
        check("unmapped_err", 32'h1, {31'h0, err});
        wr(16'h8F0C, 32'hFFFF_FFFF, 1'b0);
        check("unmapped_wr_err", 32'h1, {31'h0, err});
        wr(OFS_IRQ_MASK, 32'h0000_0007, 1'b0);
        rd_chk("irq_mask", OFS_IRQ_MASK, 32'h0000_0007, 1'b0);
        use_entry(1'b0, 1'b0, 1'b0, 4'b0000);
        use_entry(1'b1, 1'b0, 1'b1, 4'b1011);
        rd_chk("status_tag", OFS_ERR_STATUS, 32'h4200_0007, 1'b0);
        rd_chk("irq_tag", OFS_IRQ_STATUS, 32'h1, 1'b0);
        use_entry(1'b0, 1'b1, 1'b0, 4'b1111);
        rd_chk("status_ovf", OFS_ERR_STATUS, 32'h4A00_0007, 1'b0);
        rd_chk("irq_ovf", OFS_IRQ_STATUS, 32'h7, 1'b0);
        wr(OFS_ERR_STATUS, 32'h0300_0000, 1'b0);
        rd_chk("ce_clear_held", OFS_ERR_STATUS, 32'h4A00_0007, 1'b0);
        wr(OFS_ERR_STATUS, 32'h4000_0000, 1'b0);
        rd_chk("v_clear_held", OFS_ERR_STATUS, 32'h4A00_0007, 1'b0);
        wr(OFS_ERR_STATUS, 32'h4B00_0000, 1'b0);
        #1;
        check("ras_cleared", 32'h0, {31'h0, ras_irpt});
        wr(OFS_IRQ_STATUS, 32'h0000_0007, 1'b0);
        #1;
        check("irq_cleared", 32'h0, {31'h0, irq});
        use_entry(1'b1, 1'b1, 1'b1, 4'b1011);
        rd_chk("status_both", OFS_ERR_STATUS, 32'h4200_0007, 1'b0);
        rd_chk("irq_both", OFS_IRQ_STATUS, 32'h1, 1'b0);
        wr(OFS_ERR_STATUS, 32'h4B00_0000, 1'b0);
        wr(OFS_IRQ_STATUS, 32'h0000_0007, 1'b0);
        wr(OFS_IRQ_MASK, 32'h0000_0000, 1'b0);
        wr(OFS_ERR_CTRL, 32'h0000_0000, 1'b0);
        wr(OFS_INJECT_CTRL, 32'h0000_0001, 1'b0);
        tlb_wr(1'b0, 1'b1);
        use_entry(1'b0, 1'b1, 1'b1, 4'b1000);
        rd_chk("status_data", OFS_ERR_STATUS, 32'h4200_0008, 1'b0);
        rd_chk("irq_masked", OFS_IRQ_STATUS, 32'h2, 1'b0);
        wr(OFS_ERR_CTRL, 32'h0000_0008, 1'b0);
        #1;
        check("ras_reenabled", 32'h1, {31'h0, ras_irpt});
        wr(OFS_ERR_STATUS, 32'h4B00_0000, 1'b0);
        rd_chk("status_final", OFS_ERR_STATUS, 32'h0, 1'b0);
        wr(OFS_INJECT_CTRL, 32'h0000_0003, 1'b0);
        use_entry(1'b1, 1'b0, 1'b1, 4'b1010);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check("rst_outputs", 32'h0,
              {28'h0, fault, ras_irpt, irq, tag_perr_w});
        rd_chk("inject_midrst", OFS_INJECT_CTRL, 32'h0, 1'b0);
        rd_chk("status_midrst", OFS_ERR_STATUS, 32'h0, 1'b0);
        rd_chk("errctl_midrst", OFS_ERR_CTRL, RST_ERR_CTRL, 1'b0);
        rd_chk("irq_midrst", OFS_IRQ_STATUS, 32'h0, 1'b0);
        tlb_wr(1'b0, 1'b0);
        tally_and_finish();
    end
endmodule
